// *** hw/gafsl_pkg.sv ***
package gafsl_pkg;
    // ------------------------------------------------------------
    // pad bank shape
    // ------------------------------------------------------------
    localparam int          NUM_PADS     = 22;
    localparam int          PAD_RF       = 4;   // pad five, zero based
    localparam int          PAD_ALARM    = 5;   // pad six
    localparam int          PAD_BUZZ     = 6;   // pad seven
    localparam logic [21:0] ALT_CAPABLE  = 22'h000070;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DOUT      = 8'h00;
    localparam logic [7:0] OFS_DIR       = 8'h04;
    localparam logic [7:0] OFS_ALT       = 8'h08;
    localparam logic [7:0] OFS_PIN       = 8'h0c;
    localparam logic [7:0] OFS_NET       = 8'h10;
    localparam logic [7:0] OFS_ALARM     = 8'h14;
    localparam logic [7:0] OFS_BUZZ      = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          ALARM_CLR_BIT = 0;  // write one: clear command
    localparam int          BUZZ_EN_BIT   = 16; // half period minus one in [15:0]
    localparam int          IRQ_ALARM_BIT = 0;
    localparam int          IRQ_EDGE_BIT  = 1;
    localparam logic [21:0] RST_PADS      = 22'h000000;
    localparam logic [16:0] RST_BUZZ      = 17'h00000;
    localparam logic [1:0]  RST_IRQ       = 2'h0;

    // ------------------------------------------------------------
    // indicator timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int NS_PER_MS      = 1000000;
    localparam int FAST_PERIOD_MS = 1000;
    localparam int FAST_ON_MS     = 500;
    localparam int SLOW_PERIOD_MS = 3000;
    localparam int SLOW_ON_MS     = 300;
    localparam int CYC_PER_MS     = NS_PER_MS / CLK_PERIOD_NS;
    localparam int FAST_PERIOD_CYC = FAST_PERIOD_MS * CYC_PER_MS;
    localparam int FAST_ON_CYC     = FAST_ON_MS * CYC_PER_MS;
    localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_MS * CYC_PER_MS;
    localparam int SLOW_ON_CYC     = SLOW_ON_MS * CYC_PER_MS;

    // ------------------------------------------------------------
    // device network state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        NET_OFF    = 2'b00,
        NET_SEARCH = 2'b01,
        NET_REG    = 2'b10,
        NET_CALL   = 2'b11
    } gafsl_net_t;
endpackage

// *** hw/gafsl_top.sv ***
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
// Behaviour
// - each pad is set to input, output or alternate function mode.
// - an input pad is only read and returns its sampled pad level.
// - an output pad takes written levels, reads them back, and is no input.
// - an alternate pad is driven by internal function logic, not by writes.
// - only pads five, six and seven accept alternate mode.
// - pad five in alternate mode drives the rf transmit monitor.
// - pad six in alternate mode drives the alarm signal.
// - pad seven in alternate mode drives the buzzer square wave.
// - output pads drive both levels actively, push-pull.
// - the alarm rises on an alarm event and holds until the clear command.
// - the buzzer pad gives square waves on call or message events or on request.
// - the indicator is off when off, on in a call, and blinks otherwise.
// - during search the indicator blinks with 1 s period and 0.5 s on.
// - when registered it blinks with 3 s period and 0.3 s on.
// - the indicator pin is low while the lamp is lit.
module gafsl_top
#(
    parameter int P_FAST_PERIOD_CYC = gafsl_pkg::FAST_PERIOD_CYC,
    parameter int P_FAST_ON_CYC     = gafsl_pkg::FAST_ON_CYC,
    parameter int P_SLOW_PERIOD_CYC = gafsl_pkg::SLOW_PERIOD_CYC,
    parameter int P_SLOW_ON_CYC     = gafsl_pkg::SLOW_ON_CYC
)
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    input  wire logic [21:0] i_pad_in,
    output logic [21:0]      o_pad_out,
    output logic [21:0]      o_pad_oe,
    input  wire logic        i_rf_tx_active,
    input  wire logic        i_alarm_event,
    input  wire logic        i_ring_event,
    input  wire logic        i_ring_done,
    output logic             o_network_status_indicator,
    output logic             o_irq
);
    import gafsl_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [21:0] dout_ff, dir_ff, alt_ff;
    logic [21:0] pin_s1_ff, pin_s2_ff, pin_prev_ff;
    logic [2:0]  warm_ff;
    logic [1:0]  net_ff;
    logic        alarm_ff, ring_ff, buzz_wave_ff;
    logic [16:0] buzz_ff;
    logic [15:0] buzz_cnt_ff;
    logic [1:0]  irq_stat_ff, irq_mask_ff, nxt_irq_stat;
    logic [31:0] blink_cnt_ff;
    logic [1:0]  blink_net_ff;
    logic        lamp_on;
    logic [31:0] period_cyc, on_cyc;
    logic [21:0] pad_out_nxt, pad_oe_nxt, func_val;
    logic        wr_pend_ff, rd_pend_ff;
    logic [7:0]  addr_ff;
    logic        hready_ff, hresp_ff, led_ff, irq_ff;
    logic [31:0] hrdata_ff;
    logic        addr_take, wr_dout, wr_dir, wr_alt, wr_net, wr_alarm;
    logic        wr_buzz, wr_istat, wr_imask, alarm_clr, edge_evt;

    // word address decode, shared by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    assign addr_take = i_hsel && i_htrans[1] && i_hready;
    assign wr_dout   = wr_pend_ff && hit(addr_ff, OFS_DOUT);
    assign wr_dir    = wr_pend_ff && hit(addr_ff, OFS_DIR);
    assign wr_alt    = wr_pend_ff && hit(addr_ff, OFS_ALT);
    assign wr_net    = wr_pend_ff && hit(addr_ff, OFS_NET);
    assign wr_alarm  = wr_pend_ff && hit(addr_ff, OFS_ALARM);
    assign wr_buzz   = wr_pend_ff && hit(addr_ff, OFS_BUZZ);
    assign wr_istat  = wr_pend_ff && hit(addr_ff, OFS_IRQ_STAT);
    assign wr_imask  = wr_pend_ff && hit(addr_ff, OFS_IRQ_MASK);
    assign alarm_clr = wr_alarm && i_hwdata[ALARM_CLR_BIT];

    // reads take one wait state so a write just before is already visible
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
            hready_ff  <= 1'b1;
            hresp_ff   <= 1'b0;
            hrdata_ff  <= 32'h00000000;
        end
        else
        begin
            wr_pend_ff <= addr_take && i_hwrite;
            rd_pend_ff <= addr_take && !i_hwrite;
            if (addr_take)
                addr_ff <= i_haddr[7:0];
            hready_ff <= !(addr_take && !i_hwrite);
            hresp_ff  <= 1'b0;
            if (rd_pend_ff)
            begin
                unique case (1'b1)
                    hit(addr_ff, OFS_DOUT):     hrdata_ff <= {10'h000, dout_ff};
                    hit(addr_ff, OFS_DIR):      hrdata_ff <= {10'h000, dir_ff};
                    hit(addr_ff, OFS_ALT):      hrdata_ff <= {10'h000, alt_ff};
                    // output and alternate pads never report a sampled level
                    hit(addr_ff, OFS_PIN):      hrdata_ff <= {10'h000, pin_s2_ff & ~dir_ff & ~alt_ff};
                    hit(addr_ff, OFS_NET):      hrdata_ff <= {30'h00000000, net_ff};
                    hit(addr_ff, OFS_ALARM):    hrdata_ff <= {30'h00000000, ring_ff, alarm_ff};
                    hit(addr_ff, OFS_BUZZ):     hrdata_ff <= {15'h0000, buzz_ff};
                    hit(addr_ff, OFS_IRQ_STAT): hrdata_ff <= {30'h00000000, irq_stat_ff};
                    hit(addr_ff, OFS_IRQ_MASK): hrdata_ff <= {30'h00000000, irq_mask_ff};
                    default:                    hrdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // pad configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            dout_ff <= RST_PADS;
            dir_ff  <= RST_PADS;
            alt_ff  <= RST_PADS;
            net_ff  <= NET_OFF;
        end
        else
        begin
            if (wr_dout)
                dout_ff <= i_hwdata[21:0];
            if (wr_dir)
                dir_ff <= i_hwdata[21:0];
            // alternate bits on pads without a function stay zero
            if (wr_alt)
                alt_ff <= i_hwdata[21:0] & ALT_CAPABLE;
            if (wr_net)
                net_ff <= i_hwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // pad input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            pin_s1_ff   <= RST_PADS;
            pin_s2_ff   <= RST_PADS;
            pin_prev_ff <= RST_PADS;
            warm_ff     <= 3'h0;
        end
        else
        begin
            pin_s1_ff   <= i_pad_in;
            pin_s2_ff   <= pin_s1_ff;
            pin_prev_ff <= pin_s2_ff;
            warm_ff     <= {warm_ff[1:0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // alarm and ring latches
    // ------------------------------------------------------------
    // set wins over the clear command in the same cycle
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            alarm_ff <= 1'b0;
            ring_ff  <= 1'b0;
        end
        else
        begin
            alarm_ff <= i_alarm_event || (alarm_ff && !alarm_clr);
            ring_ff  <= i_ring_event || (ring_ff && !i_ring_done);
        end
    end

    // ------------------------------------------------------------
    // buzzer tone generator
    // ------------------------------------------------------------
    // tone runs on request bit or while a call or message event plays
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            buzz_ff      <= RST_BUZZ;
            buzz_cnt_ff  <= 16'h0000;
            buzz_wave_ff <= 1'b0;
        end
        else
        begin
            if (wr_buzz)
                buzz_ff <= i_hwdata[16:0];
            if (!(buzz_ff[BUZZ_EN_BIT] || ring_ff))
            begin
                buzz_cnt_ff  <= 16'h0000;
                buzz_wave_ff <= 1'b0;
            end
            else if (buzz_cnt_ff >= buzz_ff[15:0])
            begin
                buzz_cnt_ff  <= 16'h0000;
                buzz_wave_ff <= !buzz_wave_ff;
            end
            else
                buzz_cnt_ff <= buzz_cnt_ff + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // pad drive
    // ------------------------------------------------------------
    always_comb
    begin
        func_val            = 22'h000000;
        func_val[PAD_RF]    = i_rf_tx_active;
        func_val[PAD_ALARM] = alarm_ff;
        func_val[PAD_BUZZ]  = buzz_wave_ff;
    end

    generate
        for (genvar p = 0; p < NUM_PADS; p++)
        begin : g_pad
            // alternate beats the direction bit; outputs are push-pull
            assign pad_oe_nxt[p]  = alt_ff[p] || dir_ff[p];
            assign pad_out_nxt[p] = alt_ff[p] ? func_val[p] : (dir_ff[p] && dout_ff[p]);
        end
    endgenerate

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_pad_oe  <= RST_PADS;
            o_pad_out <= RST_PADS;
        end
        else
        begin
            o_pad_oe  <= pad_oe_nxt;
            o_pad_out <= pad_out_nxt;
        end
    end

    // ------------------------------------------------------------
    // network status indicator
    // ------------------------------------------------------------
    always_comb
    begin
        period_cyc = (net_ff == NET_REG) ? 32'(P_SLOW_PERIOD_CYC) : 32'(P_FAST_PERIOD_CYC);
        on_cyc     = (net_ff == NET_REG) ? 32'(P_SLOW_ON_CYC) : 32'(P_FAST_ON_CYC);
        unique case (net_ff)
            NET_OFF:    lamp_on = 1'b0;
            NET_CALL:   lamp_on = 1'b1;
            NET_SEARCH: lamp_on = blink_cnt_ff < on_cyc;
            NET_REG:    lamp_on = blink_cnt_ff < on_cyc;
        endcase
    end

    // counter restarts on a state change so each pattern opens with a lit phase
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            blink_cnt_ff <= 32'h00000000;
            blink_net_ff <= NET_OFF;
            led_ff       <= 1'b1;
        end
        else
        begin
            blink_net_ff <= net_ff;
            if (blink_net_ff != net_ff || blink_cnt_ff >= period_cyc - 32'h00000001)
                blink_cnt_ff <= 32'h00000000;
            else
                blink_cnt_ff <= blink_cnt_ff + 32'h00000001;
            led_ff <= !lamp_on;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    // pulled-up inputs would flag a false change until the synchroniser fills
    assign edge_evt = warm_ff[2] && |((pin_s2_ff ^ pin_prev_ff) & ~dir_ff & ~alt_ff);

    always_comb
    begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_istat)
            nxt_irq_stat = irq_stat_ff & ~i_hwdata[1:0];
        nxt_irq_stat[IRQ_ALARM_BIT] = nxt_irq_stat[IRQ_ALARM_BIT] || (i_alarm_event && !alarm_ff);
        nxt_irq_stat[IRQ_EDGE_BIT]  = nxt_irq_stat[IRQ_EDGE_BIT] || edge_evt;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            irq_stat_ff <= RST_IRQ;
            irq_mask_ff <= RST_IRQ;
            irq_ff      <= 1'b0;
        end
        else
        begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_imask)
                irq_mask_ff <= i_hwdata[1:0];
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    assign o_hreadyout                = hready_ff;
    assign o_hresp                    = hresp_ff;
    assign o_hrdata                   = hrdata_ff;
    assign o_network_status_indicator = led_ff;
    assign o_irq                      = irq_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_alarm_up;
        alarm_ff && !alarm_clr && !i_srst;
    endsequence

    alarm_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) s_alarm_up |=> alarm_ff)
        else $error("alarm dropped without clear");
    alarm_rise_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) i_alarm_event && !alarm_ff |=> $rose(alarm_ff) && irq_stat_ff[IRQ_ALARM_BIT])
        else $error("alarm event not latched");
    rf_pad_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) alt_ff[PAD_RF] |=> o_pad_oe[PAD_RF] && o_pad_out[PAD_RF] == $past(i_rf_tx_active))
        else $error("pad five not following rf monitor");
    alarm_pad_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) alt_ff[PAD_ALARM] |=> o_pad_out[PAD_ALARM] == $past(alarm_ff))
        else $error("pad six not following alarm");
    buzz_pad_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) alt_ff[PAD_BUZZ] |=> o_pad_out[PAD_BUZZ] == $past(buzz_wave_ff))
        else $error("pad seven not following buzzer");
    out_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) dir_ff[0] && !alt_ff[0] |=> o_pad_oe[0] && o_pad_out[0] == $past(dout_ff[0]))
        else $error("output pad not driving written level");
    in_float_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) !dir_ff[1] && !alt_ff[1] |=> !o_pad_oe[1])
        else $error("input pad driven");
    alt_only_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) (alt_ff & ~ALT_CAPABLE) == 22'h000000)
        else $error("alternate mode on a plain pad");
    reset_input_a: assert property (@(posedge i_ref_clk) $fell(i_srst) |-> dir_ff == RST_PADS && alt_ff == RST_PADS)
        else $error("pads not inputs after reset");
    led_call_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) net_ff == NET_CALL [*2] |-> !o_network_status_indicator)
        else $error("indicator pin not low in call");
    led_off_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) net_ff == NET_OFF [*2] |-> o_network_status_indicator)
        else $error("indicator pin not high when off");
    blink_wrap_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) blink_net_ff == net_ff |-> blink_cnt_ff < period_cyc)
        else $error("blink counter passed period");
    blink_phase_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) net_ff == NET_SEARCH && $stable(net_ff) |=> o_network_status_indicator == ($past(blink_cnt_ff) >= 32'(P_FAST_ON_CYC)))
        else $error("fast blink phase wrong");
endmodule

// *** dv/gafsl_pad_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// far side: external devices, pulls and the indicator lamp
// ------------------------------------------------------------
module gafsl_pad_model
(
    input  wire logic        i_ref_clk,
    input  wire logic [21:0] i_pad_out,
    input  wire logic [21:0] i_pad_oe,
    input  wire logic [21:0] i_ext_en,
    input  wire logic [21:0] i_ext_val,
    input  wire logic        i_indicator,
    output logic [21:0]      o_pad_lvl,
    output logic             o_lamp
);
    // pads 19 and 20 have no pull, so they wander when undriven
    localparam logic [21:0] PULL_UP = 22'h30e923;
    localparam logic [21:0] FLOATS  = 22'h0c0000;
    logic [21:0] float_q = 22'h0;

    // floating pads change every cycle, never a settled last value
    always @(posedge i_ref_clk)
        float_q <= ~float_q;

    // module drive first, then an external driver, then the pull
    assign o_pad_lvl = (i_pad_oe & i_pad_out)
                     | (~i_pad_oe & i_ext_en & i_ext_val)
                     | (~i_pad_oe & ~i_ext_en & ((PULL_UP & ~FLOATS) | (float_q & FLOATS)));
    // inverting transistor stage: lamp lit while the pin is low
    assign o_lamp = ~i_indicator;
endmodule

// *** dv/gpio_alt_func_status_led_tb.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module gpio_alt_func_status_led_tb;
    import gafsl_pkg::*;
    localparam int FP = 20;
    localparam int FO = 10;
    localparam int SP = 60;
    localparam int SO = 6;
    logic        clk     = 1'b0;
    logic        srst    = 1'b1;
    logic        hsel    = 1'b0;
    logic        hwr     = 1'b0;
    logic        rf      = 1'b0;
    logic        alm     = 1'b0;
    logic        ring    = 1'b0;
    logic        rdone   = 1'b0;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [21:0] ext_en  = 22'h0;
    logic [21:0] ext_val = 22'h0;
    logic        hready, hresp, ind, irq, lamp;
    logic [31:0] hrdata, rd_q;
    logic [21:0] pad_out, pad_oe, pad_lvl;
    int          compares = 0, fail_count = 0, cyc = 0, n;

    gafsl_top #(.P_FAST_PERIOD_CYC(FP), .P_FAST_ON_CYC(FO),
        .P_SLOW_PERIOD_CYC(SP), .P_SLOW_ON_CYC(SO)) u_dut
    (
        .i_ref_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_pad_in(pad_lvl), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
        .i_rf_tx_active(rf), .i_alarm_event(alm), .i_ring_event(ring),
        .i_ring_done(rdone), .o_network_status_indicator(ind), .o_irq(irq)
    );
    gafsl_pad_model u_model
    (
        .i_ref_clk(clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .i_indicator(ind), .o_pad_lvl(pad_lvl), .o_lamp(lamp)
    );

    // ------------------------------------------------------------
    // clock, hang guard and bus helpers
    // ------------------------------------------------------------
    always #5 clk = ~clk;

    // run needs about a thousand cycles; the ceiling leaves wide margin
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            $display("[FAIL] timeout exp done got hang");
            tally_and_finish();
        end
    end

    // ready and read data are taken at the rising edge, before the design updates them
    task automatic wait_rdy;
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        rd_q = hrdata;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (clk !== 1'b1)
            @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwr    <= w;
        haddr  <= {24'h0, a};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, e, rd_q)
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask

    // counts falling edges a signal stays at v, capped at 200
    task automatic run_len(input bit s, input logic v, output int c);
        c = 0;
        while (((s ? ind : pad_out[PAD_BUZZ]) === v) && c < 200)
        begin
            c++;
            @(negedge clk);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        settle(1);
        `CHK("pad_oe", 22'h0, pad_oe)
        `CHK("ind_off", 1'b1, ind)
        `CHK("irq", 1'b0, irq)
        rd(OFS_DIR, 32'h0, "dir");
        rd(OFS_ALT, 32'h0, "alt");
        rd(8'h24, 32'h0, "unmapped");
        `CHK("hresp", 1'b0, hresp)
        $display("t_reset done");
    endtask

    task automatic t_io;
        ext_en  <= 22'h3fffff;
        ext_val <= 22'h2a5a5a;
        settle(4);
        `CHK("in_oe", 22'h0, pad_oe)
        rd(OFS_PIN, 32'h002a5a5a, "pin_a");
        wr(OFS_IRQ_STAT, 32'h3);
        rd(OFS_IRQ_STAT, 32'h0, "edge_quiet");
        ext_val <= 22'h15a5a5;
        settle(4);
        rd(OFS_PIN, 32'h0015a5a5, "pin_b");
        rd(OFS_IRQ_STAT, 32'h2, "edge_seen");
        ext_en <= 22'h0;
        wr(OFS_DIR, 32'h003fffff);
        wr(OFS_DOUT, 32'h00155aa3);
        settle(2);
        `CHK("out_lvl", 22'h155aa3, pad_lvl)
        `CHK("out_oe", 22'h3fffff, pad_oe)
        rd(OFS_DOUT, 32'h00155aa3, "dout_rb");
        rd(OFS_PIN, 32'h0, "pin_out");
        $display("t_io done");
    endtask

    task automatic t_alt;
        wr(OFS_DOUT, 32'h003fffff);
        wr(OFS_ALT, 32'h003fffff);
        rd(OFS_ALT, {10'h0, ALT_CAPABLE}, "alt_rb");
        settle(2);
        `CHK("alt_pads", 22'h3fff8f, pad_out)
        @(posedge clk);
        rf <= 1'b1;
        settle(3);
        `CHK("rf_hi", 2'h3, {pad_out[PAD_RF], pad_oe[PAD_RF]})
        @(posedge clk);
        rf <= 1'b0;
        settle(3);
        `CHK("rf_lo", 1'b0, pad_out[PAD_RF])
        $display("t_alt done");
    endtask

    task automatic t_alarm;
        wr(OFS_IRQ_STAT, 32'h3);
        alm <= 1'b1;
        @(posedge clk);
        alm <= 1'b0;
        settle(3);
        `CHK("alarm_up", 1'b1, pad_out[PAD_ALARM])
        `CHK("irq_masked", 1'b0, irq)
        rd(OFS_IRQ_STAT, 32'h1, "irq_stat");
        wr(OFS_IRQ_MASK, 32'h1);
        settle(2);
        `CHK("irq_on", 1'b1, irq)
        wr(OFS_IRQ_STAT, 32'h1);
        settle(2);
        `CHK("irq_off", 1'b0, irq)
        `CHK("alarm_held", 1'b1, pad_out[PAD_ALARM])
        rd(OFS_ALARM, 32'h1, "alarm_rd");
        wr(OFS_ALARM, 32'h1);
        settle(2);
        `CHK("alarm_clr", 1'b0, pad_out[PAD_ALARM])
        $display("t_alarm done");
    endtask

    // skip a partial run, then measure one high and one low
    task automatic t_buzz;
        wr(OFS_BUZZ, 32'h00010003);
        @(negedge clk);
        run_len(1'b0, 1'b1, n);
        run_len(1'b0, 1'b0, n);
        run_len(1'b0, 1'b1, n);
        `CHK("buzz_hi", 4, n)
        run_len(1'b0, 1'b0, n);
        `CHK("buzz_lo", 4, n)
        wr(OFS_BUZZ, 32'h00000003);
        ring <= 1'b1;
        @(posedge clk);
        ring <= 1'b0;
        rd(OFS_ALARM, 32'h2, "ring_on");
        @(negedge clk);
        run_len(1'b0, 1'b1, n);
        run_len(1'b0, 1'b0, n);
        run_len(1'b0, 1'b1, n);
        `CHK("ring_hi", 4, n)
        @(posedge clk);
        rdone <= 1'b1;
        @(posedge clk);
        rdone <= 1'b0;
        settle(3);
        run_len(1'b0, 1'b0, n);
        `CHK("ring_stop", 200, n)
        $display("t_buzz done");
    endtask

    task automatic blink(input logic [31:0] st, input int lo_e, input int hi_e);
        wr(OFS_NET, st);
        @(negedge clk);
        run_len(1'b1, 1'b0, n);
        run_len(1'b1, 1'b1, n);
        run_len(1'b1, 1'b0, n);
        `CHK("lit_len", lo_e, n)
        run_len(1'b1, 1'b1, n);
        `CHK("dark_len", hi_e, n)
    endtask

    task automatic t_net;
        blink(32'h1, FO, FP - FO);
        blink(32'h2, SO, SP - SO);
        wr(OFS_NET, 32'h3);
        settle(2);
        `CHK("lamp_lit", 1'b1, lamp)
        run_len(1'b1, 1'b0, n);
        `CHK("call_on", 200, n)
        wr(OFS_NET, 32'h0);
        settle(2);
        run_len(1'b1, 1'b1, n);
        `CHK("dev_off", 200, n)
        $display("t_net done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_io();
        t_alt();
        t_alarm();
        t_buzz();
        t_net();
        tally_and_finish();
    end
endmodule
